// [rtl/asl_pkg.sv]
// ****************************************************************
// Shared constants and types for the axis servo limit monitor
// ****************************************************************
package asl_pkg;
	// Clock and sample timing
	localparam int unsigned CLK_MHZ = 50;
	localparam int unsigned SAMPLE_US = 1000;
	localparam int unsigned TICK_CYCLES = SAMPLE_US * CLK_MHZ;
	localparam int unsigned TICKS_PER_SEC = 1000000 / SAMPLE_US;
	localparam int unsigned TICKS_PER_MS = 1000 / SAMPLE_US;
	// Limit arithmetic
	localparam logic [15:0] SYNTH_MOTOR = 16'hffff;
	localparam int unsigned MOTOR_CAP_NUM = 11;
	localparam int unsigned MOTOR_CAP_DEN = 10;
	localparam int unsigned SEC_PER_MIN = 60;
	localparam int unsigned PERMIL = 1000;
	localparam int unsigned LAG_LOW_DIV = SEC_PER_MIN * PERMIL;
	localparam int unsigned LAG_HIGH_REVS = 100;
	localparam int unsigned UU_FRAC = 16;
	localparam int unsigned PCT_DIV = 100;
	// Loop gain, Q8 results
	localparam int unsigned GAIN_FRAC = 8;
	localparam int unsigned BW_NUM = 1000;
	localparam int unsigned GAIN_NUM = 60;
	// Reset values
	localparam logic [15:0] BW_RESET = 16'h0000;

	// Static axis configuration
	typedef struct packed {
		logic [15:0] maxVel;
		logic [31:0] maxAcc;
		logic [31:0] maxDec;
		logic [31:0] maxJerk;
		logic [15:0] motorMaxRpm;
		logic [15:0] motorType;
		logic [15:0] disableDelayMs;
		logic [7:0] torquePct;
		logic lagEnable;
		logic [31:0] maxLag;
		logic [31:0] maxErr;
		logic [31:0] inPositionParam;
		logic [15:0] loopTcMs;
		logic [7:0] ffPct;
		logic [23:0] countsPerRev;
		logic [31:0] userUnits;
	} asl_cfg_t;

	// Error report, refreshed every sample
	typedef struct packed {
		logic velLimit;
		logic accLimit;
		logic decLimit;
		logic jerkLimit;
		logic lagExceeded;
		logic outOfSync;
		logic driveMissing;
	} asl_err_t;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_RUN,
		ST_STOP,
		ST_HALT_WAIT,
		ST_HALT
	} asl_state_t;
endpackage : asl_pkg

// [rtl/asl_tick_div.sv]
`timescale 1ns/1ps
// ****************************************************************
// Servo sample tick divider
// ****************************************************************
module asl_tick_div #(
	parameter int unsigned CYCLES = asl_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// One-cycle sample enable
	output logic tick
);
	logic [31:0] count;

	// Free running count, one pulse per period
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= 32'h0;
			tick <= 1'b0;
		end else if (count == 32'(CYCLES - 1)) begin
			count <= 32'h0;
			tick <= 1'b1;
		end else begin
			count <= count + 32'h1;
			tick <= 1'b0;
		end
	end
endmodule : asl_tick_div

// [rtl/asl_axis_monitor.sv]
`timescale 1ns/1ps
// What this block does
// - Clamp summed velocity to maximum, flag error
// - Limit velocity increase per sample, flag error
// - Limit velocity decrease per sample, flag error
// - Limit change of acceleration, flag jerk error
// - Hold drive enabled for disable delay
// - Type 65535 means synthetic, no loop checks
// - Fault blocks motion until cleared
// - Missing drive faults axis, refuses motion
// - Velocity cap is 1.1 times motor max
// - Torque capped at percentage of available
// - Lag compare when monitoring enabled
// - Keep max lag inside derived range
// - Error beyond maximum stops servo
// - In position when error within zone
// - Gain gives 63 percent at time constant
// - Bandwidth 1000/tc, gain 60/tc
// - Zero time constant selects open loop
module asl_axis_monitor #(
	parameter int unsigned TICK_CYCLES = asl_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Configuration
	input wire asl_pkg::asl_cfg_t cfg,
	// Command sources and feedback
	input wire logic signed [31:0] pathVel,
	input wire logic signed [31:0] followVel,
	input wire logic signed [31:0] cmdPos,
	input wire logic signed [31:0] actPos,
	input wire logic signed [31:0] torqueReq,
	input wire logic [31:0] torqueAvail,
	// Control
	input wire logic driveOnReq,
	input wire logic driveAbsent,
	input wire logic faultClear,
	// Servo outputs
	output logic signed [31:0] servoVel,
	output logic signed [31:0] torqueCmd,
	output logic driveEnable,
	// Status
	output logic inPosition,
	output logic axisOk,
	output logic openLoop,
	output logic synthetic,
	output asl_pkg::asl_err_t errFlags,
	output logic [15:0] loopBandwidth,
	output logic [15:0] loopGain,
	output asl_pkg::asl_state_t axisState
);
	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic signed [33:0] clampS(input logic signed [33:0] v,
		input logic signed [33:0] lo, input logic signed [33:0] hi);
		clampS = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : clampS

	function automatic logic [33:0] absS(input logic signed [33:0] v);
		absS = (v < 0) ? 34'(-v) : 34'(v);
	endfunction : absS

	// ************************************************************
	// Sample tick and input latch
	// ************************************************************
	logic tick;
	logic evalEn;
	logic signed [31:0] pathL, followL, cmdL, actL, torqueL;
	logic [31:0] availL;
	logic driveOnL, absentL;

	asl_tick_div #(.CYCLES(TICK_CYCLES)) u_tick (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.tick(tick)
	);

	// Inputs frozen at the tick so one sample sees one snapshot
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pathL <= 32'sh0;
			followL <= 32'sh0;
			cmdL <= 32'sh0;
			actL <= 32'sh0;
			torqueL <= 32'sh0;
			availL <= 32'h0;
			driveOnL <= 1'b0;
			absentL <= 1'b0;
			evalEn <= 1'b0;
		end else begin
			evalEn <= tick;
			if (tick) begin
				pathL <= pathVel;
				followL <= followVel;
				cmdL <= cmdPos;
				actL <= actPos;
				torqueL <= torqueReq;
				availL <= torqueAvail;
				driveOnL <= driveOnReq;
				absentL <= driveAbsent;
			end
		end
	end

	// ************************************************************
	// Velocity command conditioning
	// ************************************************************
	logic signed [33:0] prevVel, prevDelta;
	logic signed [33:0] sumVel, target, velLim, motorCap, vClamp;
	logic signed [33:0] d0, dAcc, dJerk, newVel, accT, decT, jerkT;
	logic isSynth, isOpen, runEn;
	asl_pkg::asl_state_t state, next_state;

	assign isSynth = (cfg.motorType == asl_pkg::SYNTH_MOTOR);
	assign isOpen = (cfg.loopTcMs == 16'h0);
	assign runEn = (state == asl_pkg::ST_RUN) && axisOk;

	// Limits per sample; a fault or stop commands zero velocity
	always_comb begin
		sumVel = 34'(pathL) + 34'(followL);
		target = runEn ? sumVel : 34'sh0;
		motorCap = 34'(cfg.motorMaxRpm * asl_pkg::MOTOR_CAP_NUM
			/ asl_pkg::MOTOR_CAP_DEN);
		velLim = (34'(cfg.maxVel) < motorCap) ? 34'(cfg.maxVel) : motorCap;
		vClamp = clampS(target, -velLim, velLim);
		accT = 34'(cfg.maxAcc / asl_pkg::TICKS_PER_SEC);
		decT = 34'(cfg.maxDec / asl_pkg::TICKS_PER_SEC);
		jerkT = 34'(cfg.maxJerk / (asl_pkg::TICKS_PER_SEC * asl_pkg::TICKS_PER_SEC));
		d0 = vClamp - prevVel;
		dAcc = clampS(d0, -decT, accT);
		dJerk = clampS(dAcc, prevDelta - jerkT, prevDelta + jerkT);
		newVel = prevVel + dJerk;
	end

	// Command state, stepped once per sample
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prevVel <= 34'sh0;
			prevDelta <= 34'sh0;
		end else if (evalEn) begin
			prevVel <= newVel;
			prevDelta <= dJerk;
		end
	end

	// ************************************************************
	// Position supervision
	// ************************************************************
	logic signed [33:0] posErr;
	logic [33:0] absErr, maxLagEff;
	logic [71:0] lagBase, lagLow, lagHigh;
	logic checkOn, lagFault, syncFault, absentFault, faultNow, faultLatch;

	// Lag range follows the configuration, no sample needed
	always_comb begin
		lagBase = 72'(cfg.countsPerRev) * 72'(cfg.userUnits);
		lagLow = ((72'(cfg.maxVel) * lagBase) / 72'(asl_pkg::LAG_LOW_DIV))
			>> asl_pkg::UU_FRAC;
		lagHigh = (72'(asl_pkg::LAG_HIGH_REVS) * lagBase) >> asl_pkg::UU_FRAC;
		if (72'(cfg.maxLag) < lagLow) begin
			maxLagEff = 34'(lagLow);
		end else if (72'(cfg.maxLag) > lagHigh) begin
			maxLagEff = 34'(lagHigh);
		end else begin
			maxLagEff = 34'(cfg.maxLag);
		end
	end

	// Feedback checks are off in open loop and for synthetic axes
	assign posErr = 34'(cmdL) - 34'(actL);
	assign absErr = absS(posErr);
	assign checkOn = !isOpen && !isSynth;
	assign lagFault = checkOn && cfg.lagEnable && (absErr > maxLagEff);
	assign syncFault = checkOn && (absErr > 34'(cfg.maxErr));
	assign absentFault = absentL && !isSynth;
	assign faultNow = evalEn && (lagFault || syncFault || absentFault);

	// Sticky fault; a new fault wins over a clear in the same cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			faultLatch <= 1'b0;
		end else if (faultNow) begin
			faultLatch <= 1'b1;
		end else if (faultClear) begin
			faultLatch <= 1'b0;
		end
	end
	assign axisOk = !faultLatch;

	// Error report and in-position flag, refreshed per sample
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			errFlags <= '0;
			inPosition <= 1'b0;
		end else if (evalEn) begin
			errFlags.velLimit <= (vClamp != target);
			errFlags.accLimit <= (d0 > accT);
			errFlags.decLimit <= (d0 < -decT);
			errFlags.jerkLimit <= (dJerk != dAcc);
			errFlags.lagExceeded <= lagFault;
			errFlags.outOfSync <= syncFault;
			errFlags.driveMissing <= absentFault;
			inPosition <= (absErr <= 34'(cfg.inPositionParam));
		end
	end

	// ************************************************************
	// Position loop gain and servo output
	// ************************************************************
	logic signed [50:0] loopProd;
	logic signed [33:0] loopVel, ffVel;
	logic [31:0] tcWide;

	assign tcWide = 32'(cfg.loopTcMs);

	// Bandwidth 1000/tc rad/s and gain 60/tc, both Q8
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			loopBandwidth <= asl_pkg::BW_RESET;
			loopGain <= asl_pkg::BW_RESET;
		end else if (evalEn) begin
			if (isOpen) begin
				loopBandwidth <= asl_pkg::BW_RESET;
				loopGain <= asl_pkg::BW_RESET;
			end else begin
				loopBandwidth <= 16'((asl_pkg::BW_NUM << asl_pkg::GAIN_FRAC) / tcWide);
				loopGain <= 16'((asl_pkg::GAIN_NUM << asl_pkg::GAIN_FRAC) / tcWide);
			end
		end
	end

	// First order loop: error times bandwidth hits 63 percent at tc
	always_comb begin
		loopProd = 51'(posErr) * $signed({1'b0, loopBandwidth});
		loopVel = (checkOn && driveEnable) ? 34'(loopProd >>> asl_pkg::GAIN_FRAC)
			: 34'sh0;
		ffVel = 34'((44'(newVel) * $signed({1'b0, cfg.ffPct}))
			/ $signed(44'(asl_pkg::PCT_DIV)));
	end

	// Torque clamp and servo velocity registers
	logic signed [33:0] torqueLim;
	assign torqueLim = 34'((64'(availL) * 64'(cfg.torquePct)) / 64'(asl_pkg::PCT_DIV));

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			servoVel <= 32'sh0;
			torqueCmd <= 32'sh0;
		end else if (evalEn) begin
			servoVel <= 32'(ffVel + loopVel);
			torqueCmd <= 32'(clampS(34'(torqueL), -torqueLim, torqueLim));
		end
	end

	assign openLoop = isOpen;
	assign synthetic = isSynth;

	// ************************************************************
	// Drive enable sequencing
	// ************************************************************
	logic [31:0] delayCnt;

	// Next state; a stop or fault first zeroes velocity, then waits
	always_comb begin
		next_state = state;
		case (state)
			asl_pkg::ST_OFF: begin
				if (driveOnL && axisOk) begin
					next_state = asl_pkg::ST_RUN;
				end
			end
			asl_pkg::ST_RUN: begin
				if (!axisOk) begin
					next_state = asl_pkg::ST_HALT_WAIT;
				end else if (!driveOnL) begin
					next_state = asl_pkg::ST_STOP;
				end
			end
			asl_pkg::ST_STOP: begin
				if (!axisOk) begin
					next_state = asl_pkg::ST_HALT_WAIT;
				end else if (delayCnt == 32'h0) begin
					next_state = asl_pkg::ST_OFF;
				end
			end
			asl_pkg::ST_HALT_WAIT: begin
				if (delayCnt == 32'h0) begin
					next_state = asl_pkg::ST_HALT;
				end
			end
			asl_pkg::ST_HALT: begin
				if (axisOk && !driveOnL) begin
					next_state = asl_pkg::ST_OFF;
				end
			end
			default: next_state = asl_pkg::ST_OFF;
		endcase
	end

	// Delay counts its entry sample too, else the drive stays on one sample long
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= asl_pkg::ST_OFF;
			delayCnt <= 32'h0;
			driveEnable <= 1'b0;
		end else if (evalEn) begin
			state <= next_state;
			if (state == asl_pkg::ST_RUN) begin
				delayCnt <= 32'(cfg.disableDelayMs) * 32'(asl_pkg::TICKS_PER_MS)
					- 32'(cfg.disableDelayMs != 16'h0);
			end else if (delayCnt != 32'h0) begin
				delayCnt <= delayCnt - 32'h1;
			end
			driveEnable <= (next_state == asl_pkg::ST_RUN) || (next_state == asl_pkg::ST_STOP)
				|| (next_state == asl_pkg::ST_HALT_WAIT);
		end
	end
	assign axisState = state;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	velBound_a: assert property (prevVel <= velLim && prevVel >= -velLim || $changed(cfg)
		|| $past(velLim) != velLim || !$past(evalEn)) else $error("velocity over limit");
	velFlag_a: assert property (evalEn && (target > velLim) |=> errFlags.velLimit)
		else $error("velocity clamp not reported");
	accStep_a: assert property (evalEn |=> (prevVel - $past(prevVel)) <= $past(accT))
		else $error("acceleration step too large");
	decStep_a: assert property (evalEn |=> ($past(prevVel) - prevVel) <= $past(decT))
		else $error("deceleration step too large");
	jerkStep_a: assert property (evalEn |=> absS(prevDelta - $past(prevDelta)) <= 34'($past(jerkT)))
		else $error("jerk step too large");
	stopHold_a: assert property (evalEn && state == asl_pkg::ST_STOP && delayCnt != 32'h0 && axisOk
		|=> driveEnable) else $error("drive dropped before delay");
	synthNoFault_a: assert property (evalEn && isSynth |-> !faultNow)
		else $error("synthetic axis faulted");
	faultBlock_a: assert property (!axisOk && evalEn |=> state != asl_pkg::ST_RUN)
		else $error("motion while faulted");
	absentFault_a: assert property (evalEn && absentL && !isSynth |=> !axisOk)
		else $error("missing drive not faulted");
	torqueCap_a: assert property (evalEn |=> absS(34'(torqueCmd)) <= 34'($past(torqueLim)))
		else $error("torque over limit");
	syncStop_a: assert property (evalEn && syncFault |=> !axisOk ##1 !runEn)
		else $error("out of sync not stopped");
	inZone_a: assert property (evalEn |=> inPosition == ($past(absErr) <= 34'(cfg.inPositionParam)))
		else $error("in position flag wrong");
	bandwidth_a: assert property (evalEn && !isOpen |=> loopBandwidth
		== 16'((asl_pkg::BW_NUM << asl_pkg::GAIN_FRAC) / $past(tcWide)))
		else $error("bandwidth wrong");
	openLoop_a: assert property (isOpen |-> loopVel == 34'sh0)
		else $error("feedback used in open loop");

	runCov_c: cover property (state == asl_pkg::ST_OFF ##1 state == asl_pkg::ST_RUN);
	haltCov_c: cover property (state == asl_pkg::ST_HALT_WAIT ##1 state == asl_pkg::ST_HALT);
	accCov_c: cover property (errFlags.accLimit && errFlags.jerkLimit);
	inPosCov_c: cover property (inPosition && state == asl_pkg::ST_RUN);
endmodule : asl_axis_monitor

// [testbench/asl_servo_model.sv]
`timescale 1ns/1ps
// ****************************************
// Amplifier and motor stand-in
// ****************************************
module asl_servo_model #(
	parameter int unsigned TICK = 10
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Amplifier command
	input wire logic signed [31:0] servoVel,
	input wire logic driveEnable,
	// Jammed shaft, held by the bench
	input wire logic stall,
	// Feedback
	output logic signed [31:0] actPos
);
	int cnt;

	// Shaft integrates speed once a sample; coasting is not modelled
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 0;
			actPos <= 32'sh00001000;
		end else begin
			cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
			if (cnt == 0 && driveEnable && !stall)
				actPos <= actPos + (servoVel >>> 4);
		end
	end
endmodule : asl_servo_model

// [testbench/tb_axis_servo_limit_and_lag_monitor.sv]
`timescale 1ns/1ps
// ****************************************
// Bench for the axis limit and lag monitor
// ****************************************
module tb_axis_servo_limit_and_lag_monitor;
	localparam int unsigned TICK = 10;
	localparam logic signed [31:0] P0 = 32'sh00001000;
	logic sys_clk, rst_n, driveOnReq, driveAbsent, faultClear, stall;
	logic driveEnable, inPosition, axisOk, openLoop, synthetic;
	logic signed [31:0] pathVel, followVel, cmdPos, actPos, torqueReq, servoVel, torqueCmd;
	logic [31:0] torqueAvail;
	logic [15:0] loopBandwidth, loopGain;
	asl_pkg::asl_cfg_t cfg;
	asl_pkg::asl_err_t errFlags;
	asl_pkg::asl_state_t axisState;
	int errCount, checks, cycles, n, i, k;
	// Zone offsets, torque requests and expected answers
	logic signed [31:0] offs [3] = '{32'sh0000000a, 32'sh0000000b, -32'sh0000000a};
	logic signed [31:0] tqIn [3] = '{32'sh000003e8, -32'sh000003e8, 32'sh0000012c};
	logic signed [31:0] tqExp [3] = '{32'sh000001f4, -32'sh000001f4, 32'sh0000012c};
	logic [2:0] inExp = 3'h5;
	logic signed [31:0] decExp [4] = '{32'sh00000046, 32'sh00000028, 32'sh0000000a, 32'sh0};

	asl_axis_monitor #(.TICK_CYCLES(TICK)) uut (.sys_clk, .rst_n, .cfg, .pathVel, .followVel,
		.cmdPos, .actPos, .torqueReq, .torqueAvail, .driveOnReq, .driveAbsent, .faultClear,
		.servoVel, .torqueCmd, .driveEnable, .inPosition, .axisOk, .openLoop, .synthetic,
		.errFlags, .loopBandwidth, .loopGain, .axisState);
	asl_servo_model #(.TICK(TICK)) motor (.sys_clk, .rst_n, .servoVel, .driveEnable, .stall,
		.actPos);

	// System clock
	always #10 sys_clk = ~sys_clk;

	// Hang guard; the run needs roughly 960 cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			errCount++;
			stopTest();
		end
	end

	task automatic cmpV(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			errCount++;
			$display("wrong value at %0t: %s got %0h exp %0h", $time, msg, got, exp);
		end
	endtask : cmpV

	task automatic cmpS(input asl_pkg::asl_state_t got, input asl_pkg::asl_state_t exp,
		input string msg);
		checks++;
		if (got !== exp) begin
			errCount++;
			$display("wrong value at %0t: %s state %0d exp %0d", $time, msg, got, exp);
		end
	endtask : cmpS

	// Whole samples; keeps the bench mid-way between evaluations
	task automatic smp(input int c);
		repeat (c * TICK) @(negedge sys_clk);
	endtask : smp

	task automatic waitSt(input asl_pkg::asl_state_t st);
		for (int j = 0; j < 6 && axisState !== st; j++)
			smp(1);
	endtask : waitSt

	// Aligns on the first moving sample only, bounded
	task automatic waitMove();
		for (int j = 0; j < 6 && servoVel === 32'sh0; j++)
			smp(1);
	endtask : waitMove

	task automatic endT(input string name);
		$display("test %s done", name);
	endtask : endT

	// Timed stop after a fault, then clear and re-arm
	task automatic haltSeq();
		n = 0;
		for (int j = 0; j < 12; j++) begin
			smp(1);
			if (axisState === asl_pkg::ST_HALT_WAIT)
				n++;
		end
		cmpV(n, cfg.disableDelayMs, "halt delay");
		cmpS(axisState, asl_pkg::ST_HALT, "halted");
		cmpV(driveEnable, 1'b0, "drive off");
		cmpV(servoVel, 32'sh0, "no motion");
		faultClear = 1'b1;
		smp(1);
		faultClear = 1'b0;
		smp(1);
		cmpV(axisOk, 1'b1, "cleared");
		cmpS(axisState, asl_pkg::ST_HALT, "no restart");
		driveOnReq = 1'b0;
		smp(2);
		cmpS(axisState, asl_pkg::ST_OFF, "re-armed");
	endtask : haltSeq

	task automatic stopTest();
		$display("checks %0d mismatches %0d", checks, errCount);
		if (errCount == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stopTest

	// Main sequence
	initial begin
		sys_clk = 1'b0;
		rst_n = 1'b0;
		driveOnReq = 1'b0;
		driveAbsent = 1'b0;
		faultClear = 1'b0;
		stall = 1'b0;
		pathVel = 32'sh0;
		followVel = 32'sh0;
		cmdPos = P0;
		torqueReq = 32'sh0;
		torqueAvail = 32'h000007d0;
		// One real axis, type 0; the last test below makes it synthetic
		cfg = '{maxVel: 16'h0064, maxAcc: 32'h00004e20, maxDec: 32'h00007530,
			maxJerk: 32'h3b9aca00, motorMaxRpm: 16'h0bb8, motorType: 16'h0000,
			disableDelayMs: 16'h0006, // Exceeds the 4 sample stop
			torquePct: 8'h19, lagEnable: 1'b1,
			maxLag: 32'h000001f4, // Below error limit, margin over normal
			maxErr: 32'h000003e8, inPositionParam: 32'h0000000a,
			loopTcMs: 16'h0014, // Long against the ramps
			ffPct: 8'h64, countsPerRev: 24'h0003e8, userUnits: 32'h00010000};
		repeat (2) @(negedge sys_clk);
		cmpS(axisState, asl_pkg::ST_OFF, "reset state");
		cmpV(driveEnable, 1'b0, "reset drive");
		cmpV(axisOk, 1'b1, "reset ok");
		@(negedge sys_clk);
		rst_n = 1'b1;
		repeat (TICK + TICK / 2) @(negedge sys_clk);
		cmpV(loopBandwidth, 16'h3200, "bandwidth");
		cmpV(loopGain, 16'h0300, "gain");
		cmpV(openLoop, 1'b0, "closed");
		endT("reset");
		// Zone edge and torque clamp, one sample each
		for (i = 0; i < 3; i++) begin
			cmdPos = P0 + offs[i];
			torqueReq = tqIn[i];
			smp(1);
			cmpV(inPosition, inExp[i], "zone");
			cmpV(torqueCmd, tqExp[i], "torque");
		end
		cmdPos = P0 + 32'sh00000064;
		repeat (2) @(negedge sys_clk);
		cmpV(inPosition, 1'b1, "held");
		repeat (TICK - 2) @(negedge sys_clk);
		cmpV(inPosition, 1'b0, "out");
		endT("zone");
		// Jammed motor: lag, then loss of sync
		stall = 1'b1;
		cfg.countsPerRev = 24'h000004; // Upper lag bound 400 cuts max lag
		cmdPos = P0;
		driveOnReq = 1'b1;
		waitSt(asl_pkg::ST_RUN);
		cmdPos = P0 + 32'sh00000190;
		smp(1);
		cmpV(errFlags.lagExceeded, 1'b0, "lag edge");
		cmdPos = P0 + 32'sh00000191;
		smp(1);
		cmpV(errFlags.lagExceeded, 1'b1, "lag");
		cmpV(errFlags.outOfSync, 1'b0, "sync");
		// Clear the lag fault so only the sync check can drop the axis
		cfg.lagEnable = 1'b0;
		faultClear = 1'b1;
		@(negedge sys_clk);
		faultClear = 1'b0;
		cmdPos = P0 + 32'sh000003e9;
		smp(1);
		cmdPos = P0;
		cmpV(errFlags.outOfSync, 1'b1, "unsync");
		cmpV(axisOk, 1'b0, "sync fault");
		haltSeq();
		stall = 1'b0;
		endT("lag");
		// Open loop ramp from two sources
		cfg.loopTcMs = 16'h0000;
		pathVel = 32'sh00000050;
		followVel = 32'sh00000032;
		smp(1);
		cmpV(openLoop, 1'b1, "open");
		cmpV(loopBandwidth, 16'h0000, "open bw");
		driveOnReq = 1'b1;
		waitMove();
		for (i = 0; i < 6; i++) begin
			cmpV(servoVel, (i < 5) ? 32'sh14 * (i + 1) : 32'sh64, "ramp");
			if (i == 0) begin
				cmpV(errFlags.velLimit, 1'b1, "vel flag");
				cmpV(errFlags.accLimit, 1'b1, "acc flag");
			end
			smp(1);
		end
		cmpV(errFlags.accLimit, 1'b0, "plateau");
		// Stop: decel ramp and disable delay
		driveOnReq = 1'b0;
		n = 0;
		k = 0;
		for (i = 0; i < 12; i++) begin
			smp(1);
			if (axisState === asl_pkg::ST_STOP)
				n++;
			if (servoVel !== 32'sh64 && k < 4) begin
				cmpV(servoVel, decExp[k], "decel");
				if (k == 0)
					cmpV(errFlags.decLimit, 1'b1, "dec flag");
				k++;
			end
		end
		cmpV(n, cfg.disableDelayMs, "stop delay");
		cmpS(axisState, asl_pkg::ST_OFF, "stopped");
		cmpV(driveEnable, 1'b0, "disabled");
		endT("ramp");
		// Motor rating caps the speed
		cfg.maxVel = 16'h00c8;
		cfg.motorMaxRpm = 16'h0064;
		cfg.maxAcc = 32'h00989680;
		pathVel = 32'sh000001f4;
		driveOnReq = 1'b1;
		smp(5);
		cmpV(servoVel, 32'sh0000006e, "cap");
		cmpV(errFlags.velLimit, 1'b1, "cap flag");
		driveOnReq = 1'b0;
		smp(10);
		endT("cap");
		// Jerk shapes the start
		cfg.maxVel = 16'h0064;
		cfg.motorMaxRpm = 16'h0bb8;
		cfg.maxAcc = 32'h00004e20;
		cfg.maxJerk = 32'h004c4b40;
		pathVel = 32'sh00000050;
		driveOnReq = 1'b1;
		waitMove();
		cmpV(servoVel, 32'sh5, "jerk 1");
		cmpV(errFlags.jerkLimit, 1'b1, "jerk flag");
		smp(1);
		cmpV(servoVel, 32'shf, "jerk 2");
		driveOnReq = 1'b0;
		smp(10);
		endT("jerk");
		// Missing drive faults the axis
		cfg.maxJerk = 32'h3b9aca00;
		driveOnReq = 1'b1;
		waitSt(asl_pkg::ST_RUN);
		driveAbsent = 1'b1;
		smp(1);
		driveAbsent = 1'b0;
		cmpV(errFlags.driveMissing, 1'b1, "missing");
		cmpV(axisOk, 1'b0, "faulted");
		haltSeq();
		endT("drive");
		// Synthetic axis ignores the drive link
		cfg.motorType = 16'hffff;
		driveOnReq = 1'b1;
		smp(1);
		cmpV(synthetic, 1'b1, "synthetic");
		waitSt(asl_pkg::ST_RUN);
		driveAbsent = 1'b1;
		smp(2);
		cmpV(axisOk, 1'b1, "synth ok");
		cmpV(errFlags.driveMissing, 1'b0, "synth flag");
		cmpS(axisState, asl_pkg::ST_RUN, "synth run");
		endT("synthetic");
		stopTest();
	end
endmodule : tb_axis_servo_limit_and_lag_monitor
